// ---- design/bit_skip_call_pkg.sv ----
// constants for the bit set, bit skip and call execution block
// assumes a 12-bit instruction word and 8-bit data path on one clock
package bit_skip_call_pkg;
  localparam int          INSN_W       = 12;
  localparam int          PC_W         = 11;
  localparam logic [3:0]  OP_BIT_SET   = 4'h5;
  localparam logic [3:0]  OP_SKIP_CLR  = 4'h6;
  localparam logic [3:0]  OP_SKIP_SET  = 4'h7;
  localparam logic [3:0]  OP_CALL      = 4'h9;
  localparam int          BIT_LSB      = 5;
  localparam int          REG_MSB      = 4;
  localparam int          STAT_PAGE_LO = 5;
  localparam logic [10:0] PC_RST       = 11'h7ff;
endpackage

// ---- design/bit_skip_call_exec.sv ----
// executes bit set, both bit skips and call for the core
// assumes register file read data valid combinationally for the addressed register
`timescale 1ns/10ps
module bit_skip_call_exec (
  input  wire logic                                   clk_sys_in,
  input  wire logic                                   rst_n_in,
  input  wire logic [bit_skip_call_pkg::INSN_W-1:0]   insn_in,
  input  wire logic                                   insn_valid_in,
  input  wire logic [7:0]                             reg_rdata_in,
  input  wire logic [7:0]                             status_in,
  input  wire logic [bit_skip_call_pkg::PC_W-1:0]     pc_in,
  output logic      [4:0]                             reg_addr_out,
  output logic                                        reg_we_out,
  output logic      [7:0]                             reg_wdata_out,
  output logic                                        push_out,
  output logic      [bit_skip_call_pkg::PC_W-1:0]     push_data_out,
  output logic                                        pc_load_out,
  output logic      [bit_skip_call_pkg::PC_W-1:0]     pc_next_out,
  output logic                                        squash_out
);
  import bit_skip_call_pkg::*;

  logic [3:0] opcode;
  logic [2:0] bit_idx;
  logic       tested;
  logic       squash_ff;
  logic       live;
  logic       do_skip;

  ////////////////////////////////////////////////////////////////////////
  // field decode
  assign opcode  = insn_in[INSN_W-1 -: 4];
  assign bit_idx = insn_in[BIT_LSB+2:BIT_LSB];
  assign tested  = reg_rdata_in[bit_idx];
  // a squashed slot behaves as a no-op: nothing is written
  assign live    = insn_valid_in && !squash_ff;
  assign do_skip = live && ((opcode == OP_SKIP_CLR && !tested) ||
                            (opcode == OP_SKIP_SET && tested));

  // per-operation strobes of a live slot, shared by the checks below
  logic act_set;
  logic act_clr;
  logic act_sset;
  logic act_call;
  assign act_set  = live && opcode == OP_BIT_SET;
  assign act_clr  = live && opcode == OP_SKIP_CLR;
  assign act_sset = live && opcode == OP_SKIP_SET;
  assign act_call = live && opcode == OP_CALL;

  ////////////////////////////////////////////////////////////////////////
  // squash of the prefetched word; held until the slot is consumed
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      squash_ff <= 1'b0;
    end else if (insn_valid_in) begin
      squash_ff <= do_skip || (live && opcode == OP_CALL);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register write for bit set; status never touched
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reg_addr_out  <= 5'h00;
      reg_we_out    <= 1'b0;
      reg_wdata_out <= 8'h00;
    end else begin
      reg_addr_out  <= insn_in[REG_MSB:0];
      reg_we_out    <= live && opcode == OP_BIT_SET;
      reg_wdata_out <= reg_rdata_in | (8'h01 << bit_idx);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // call: push return address, form target
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      push_out      <= 1'b0;
      push_data_out <= PC_RST;
      pc_load_out   <= 1'b0;
      pc_next_out   <= PC_RST;
    end else begin
      push_out      <= live && opcode == OP_CALL;
      push_data_out <= PC_W'(pc_in + 11'h001);
      pc_load_out   <= live && opcode == OP_CALL;
      // bit 8 forced low, page from status
      pc_next_out   <= {status_in[STAT_PAGE_LO+1:STAT_PAGE_LO], 1'b0,
                        insn_in[7:0]};
    end
  end

  // squash pulse for the fetch path; only one cycle, the flag above holds it
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      squash_out <= 1'b0;
    end else begin
      squash_out <= do_skip || (live && opcode == OP_CALL);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks: each property looks one cycle after the taking edge
  // latency is fixed at one, so a plain next-cycle implication is exact
  // reset disables them all; the first edge after release is checked normally

  // bit set writes read data with the chosen bit forced high
  AST_SET_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    live && opcode == OP_BIT_SET |=> reg_we_out &&
      reg_wdata_out == ($past(reg_rdata_in) | (8'h01 << $past(bit_idx))))
    else $error("bit set write wrong");

  // clear skip with a zero bit squashes the next slot
  AST_SKIP_CLR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    live && opcode == OP_SKIP_CLR && !tested |=> squash_out)
    else $error("clear skip not taken");

  // a squashed slot is a no-op
  AST_NOSQUASH_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    squash_ff && insn_valid_in |=> !reg_we_out && !push_out && !pc_load_out)
    else $error("squashed slot had effect");

  // set skip follows the tested bit
  AST_SKIP_SET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    live && opcode == OP_SKIP_SET |=> squash_out == $past(tested))
    else $error("set skip wrong");

  // clear skip with a one bit runs in one cycle
  AST_NO_FALSE_SKIP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    live && opcode == OP_SKIP_CLR && tested |=> !squash_out)
    else $error("clear skip taken falsely");

  // call pushes the return address
  AST_CALL_PUSH: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    live && opcode == OP_CALL |=> push_out && push_data_out == $past(pc_in) + 11'h001)
    else $error("call push wrong");

  // call target: page, cleared bit 8, literal
  AST_CALL_TARGET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    live && opcode == OP_CALL |=> pc_load_out && !pc_next_out[8] &&
      pc_next_out[10:9] == $past(status_in[6:5]) && pc_next_out[7:0] == $past(insn_in[7:0]))
    else $error("call target wrong");

  // call throws away the sequential fetch
  AST_CALL_SQUASH: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    live && opcode == OP_CALL |=> squash_out && squash_ff)
    else $error("call did not discard fetch");

  // the pending squash survives empty cycles
  AST_SQUASH_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !insn_valid_in |=> squash_ff == $past(squash_ff))
    else $error("pending squash lost");

  // a consumed squashed slot clears the flag and raises nothing
  AST_SLOT_CONSUMED: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    squash_ff && insn_valid_in |=> !squash_ff && !squash_out)
    else $error("squash not consumed");

  // set skip on a zero bit is single cycle
  AST_SSET_NOSKIP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    act_sset && !tested |=> !squash_out)
    else $error("set skip taken falsely");

  // taken set skip arms the squash flag
  AST_SSET_SQUASH: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    act_sset && tested |=> squash_ff)
    else $error("set skip did not arm squash");

  // taken clear skip arms the squash flag
  AST_CLR_SQUASH: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    act_clr && !tested |=> squash_ff)
    else $error("clear skip did not arm squash");

  // no write strobe without a live bit set
  AST_WE_ONLY_SET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !act_set |=> !reg_we_out)
    else $error("stray register write");

  // write address is the register field
  AST_SET_ADDR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    act_set |=> reg_addr_out == $past(insn_in[4:0]))
    else $error("bit set address wrong");

  // no push without a live call
  AST_PUSH_ONLY_CALL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !act_call |=> !push_out)
    else $error("stray push");

  // no pc load without a live call
  AST_LOAD_ONLY_CALL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !act_call |=> !pc_load_out)
    else $error("stray pc load");

  // a dead slot never asks for another squash
  AST_SQUASH_CAUSE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !live |=> !squash_out)
    else $error("squash from dead slot");

  // skips only test; they write, push and load nothing
  AST_SKIP_NO_EFFECT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    act_clr || act_sset |=> !reg_we_out && !push_out && !pc_load_out)
    else $error("skip had side effect");

  // call low target bits carry the literal
  AST_CALL_LITERAL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    act_call |=> pc_next_out[7:0] == $past(insn_in[7:0]))
    else $error("call literal wrong");

  // call page bits come from status
  AST_CALL_PAGE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    act_call |=> pc_next_out[10:9] == $past(status_in[6:5]))
    else $error("call page wrong");

  // call writes no register
  AST_CALL_NO_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    act_call |=> !reg_we_out)
    else $error("call wrote a register");

  // bit set is one cycle: no squash, no push
  AST_SET_NO_SQUASH: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    act_set |=> !squash_out && !push_out)
    else $error("bit set took a second cycle");

  // bit set leaves all other bits as read
  AST_BIT_INDEX: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    act_set |=> (reg_wdata_out & ~(8'h01 << $past(insn_in[7:5]))) ==
      ($past(reg_rdata_in) & ~(8'h01 << $past(insn_in[7:5]))))
    else $error("bit set disturbed other bits");
endmodule

// ---- verif/reg_file_model.sv ----
// register file on the far side of the bit and skip block
// assumes the block writes on the rising clock edge
`timescale 1ns/10ps
module reg_file_model (
  input  wire logic       clk_sys_in,
  input  wire logic [4:0] rd_addr_in,
  input  wire logic       we_in,
  input  wire logic [4:0] wr_addr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem_ff [32];
  // combinational read, the block samples it in the same cycle
  assign rdata_out = mem_ff[rd_addr_in];
  // every register starts at 0a so bits 1 and 0 differ
  initial begin
    foreach (mem_ff[i]) mem_ff[i] = 8'h0a;
  end
  always @(posedge clk_sys_in) begin
    if (we_in) mem_ff[wr_addr_in] <= wdata_in;
  end
endmodule

// ---- verif/tb_bit_skip_call_exec.sv ----
// self-checking bench for the bit set, skip and call block
// assumes register file model answers reads combinationally
`timescale 1ns/10ps
module tb_bit_skip_call_exec;
  logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, insn_valid_in = 1'b0;
  logic [11:0] insn_in = 12'h000;
  logic [7:0]  status_in = 8'h60, reg_rdata_in, reg_wdata_out;
  logic [10:0] pc_in = 11'h010, push_data_out, pc_next_out;
  logic [4:0]  reg_addr_out;
  logic        reg_we_out, push_out, pc_load_out, squash_out;
  int          n_fail = 0, num_checks = 0;
  bit_skip_call_exec bit_skip_call_exec_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .insn_in(insn_in), .insn_valid_in(insn_valid_in), .reg_rdata_in(reg_rdata_in),
    .status_in(status_in), .pc_in(pc_in), .reg_addr_out(reg_addr_out),
    .reg_we_out(reg_we_out), .reg_wdata_out(reg_wdata_out), .push_out(push_out),
    .push_data_out(push_data_out), .pc_load_out(pc_load_out),
    .pc_next_out(pc_next_out), .squash_out(squash_out));
  reg_file_model reg_file_model_i (.clk_sys_in(clk_sys_in), .rd_addr_in(insn_in[4:0]),
    .we_in(reg_we_out), .wr_addr_in(reg_addr_out), .wdata_in(reg_wdata_out),
    .rdata_out(reg_rdata_in));
  initial begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // one slot per cycle; pc steps so push data differs each time
  task automatic step(input logic [11:0] w);
    @(negedge clk_sys_in);
    insn_in = w;
    insn_valid_in = 1'b1;
    pc_in = pc_in + 11'h001;
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic t_set();
    step(12'h5a3);
    chk(reg_we_out, 1'b1);
    chk(reg_addr_out, 5'h03);
    chk(reg_wdata_out, 8'h2a);
    step(12'h5e4);
    chk(reg_wdata_out, 8'h8a);
    chk(squash_out, 1'b0);
  endtask
  task automatic t_skip();
    step(12'h605);
    chk(squash_out, 1'b1);
    step(12'h5e5);
    chk(reg_we_out, 1'b0);
    step(12'h625);
    chk(squash_out, 1'b0);
    step(12'h725);
    chk(squash_out, 1'b1);
    step(12'h9ff);
    chk({push_out, pc_load_out}, 2'b00);
    step(12'h705);
    chk(squash_out, 1'b0);
  endtask
  task automatic t_call();
    step(12'h9c3);
    chk(push_out, 1'b1);
    chk(push_data_out, pc_in + 11'h001);
    chk(pc_load_out, 1'b1);
    chk(pc_next_out, 11'h6c3);
    chk(squash_out, 1'b1);
    step(12'h5e6);
    chk({reg_we_out, push_out, pc_load_out}, 3'b000);
  endtask
  // empty cycle: a pending squash must wait for the next real slot
  task automatic t_hold();
    step(12'h725);
    chk(squash_out, 1'b1);
    @(negedge clk_sys_in);
    insn_valid_in = 1'b0;
    @(posedge clk_sys_in);
    #1;
    chk(squash_out, 1'b0);
    step(12'h5e5);
    chk(reg_we_out, 1'b0);
    step(12'h5e5);
    chk(reg_we_out, 1'b1);
    chk(reg_wdata_out, 8'h8a);
  endtask
  // opcodes outside the four do nothing here
  task automatic t_refuse();
    step(12'h3e5);
    chk({reg_we_out, push_out, pc_load_out, squash_out}, 4'h0);
    step(12'h4e5);
    chk({reg_we_out, push_out, pc_load_out, squash_out}, 4'h0);
  endtask
  // page bits zero while status bits 7 and 4:0 are set
  task automatic t_call_page();
    status_in = 8'h9f;
    step(12'h95a);
    chk(pc_next_out, 11'h05a);
    chk(pc_load_out, 1'b1);
    step(12'h000);
    chk({push_out, pc_load_out, squash_out}, 3'h0);
  endtask
  // reset in mid-run drops a pending squash
  task automatic t_reset();
    step(12'h9c3);
    chk(squash_out, 1'b1);
    @(negedge clk_sys_in);
    rst_n_in = 1'b0;
    insn_valid_in = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk({push_out, pc_load_out, squash_out, reg_we_out}, 4'h0);
    chk(pc_next_out, 11'h7ff);
    chk(push_data_out, 11'h7ff);
    @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    step(12'h5a3);
    chk(reg_we_out, 1'b1);
    chk(reg_wdata_out, 8'h2a);
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // reset held for five cycles, released off the sampling edge
  initial begin
    repeat (5) @(posedge clk_sys_in);
    @(negedge clk_sys_in) rst_n_in = 1'b1;
    t_set();
    t_skip();
    t_call();
    t_hold();
    t_refuse();
    t_call_page();
    t_reset();
    report_and_stop();
  end
  // about 29 cycles of work; 500 cycles is ample margin
  initial begin
    #2000;
    n_fail++;
    report_and_stop();
  end
endmodule
